/* File: design/adc_ctl_pkg.sv */
// Functional notes
// - 10-bit result, one of eight channels
// - trigger edge: rising, falling or both
// - trigger start: one conversion, halt, irq
// - software start: back to back, irq each
// - resolve msb first, keep decided bits
// - after lsb copy value to result
// - result 16 bits, low six read zero
// - reset clears result register
// - mode takes bit and byte writes, resets zero
// - mode layout: run,source,time,edge,zero
// - run bit 0 stops, 1 enables
// - source bit picks software or trigger
// - edge also gated by edge enable bit 3
// - trigger mode waits in standby for edge
// - edge code 00 none,01 fall,10 rise,11 both
// - channel write aborts; restart or await trigger
// - channel 3-bit code, reset zero
package adc_ctl_pkg;
  localparam logic [15:0] MODE_ADDR = 16'hFF80;
  localparam logic [15:0] CHAN_ADDR = 16'hFF81;
  localparam logic [15:0] RISE_EN_ADDR = 16'hFF49;
  localparam logic [15:0] FALL_EN_ADDR = 16'hFF48;
  localparam logic [15:0] RESULT_ADDR = 16'hFF1E;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'hFE;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int RUN_BIT = 7;
  localparam int SRC_BIT = 6;
  localparam int TIME_LO = 3;
  localparam int EDGE_LO = 1;
  localparam int TRIG_EN_BIT = 3;
  localparam int RES_BITS = 10;
  localparam int RES_SHIFT = 6;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // cycles per comparison step for each time code, 125 MHz core
  localparam int STEP_CYC_0 = 14;
  localparam int STEP_CYC_1 = 12;
  localparam int STEP_CYC_OTHER = 14;

  typedef struct packed {
    logic run;
    logic src_trig;
    logic [2:0] time_sel;
    logic [1:0] edge_sel;
    logic zero;
  } mode_t;

  typedef struct packed {
    logic wr;
    logic bit_wr;
    logic [2:0] bit_idx;
    logic bit_val;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cpu_req_t;
endpackage : adc_ctl_pkg

/* File: design/adc_sar_core.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_sar_core
  import adc_ctl_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // control
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [7:0] i_step_cyc,
  input wire logic i_cmp_ge,
  // results
  output logic [RES_BITS-1:0] o_trial,
  output logic o_busy,
  output logic o_done,
  output logic [RES_BITS-1:0] o_value
);
  logic [RES_BITS-1:0] approximation_shift_reg_q;
  logic [RES_BITS-1:0] probe_q;
  logic [7:0] cnt_q;
  logic busy_q;
  logic done_q;

  assign o_trial = approximation_shift_reg_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_value = approximation_shift_reg_q;

  // one bit per step, msb first
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      approximation_shift_reg_q <= '0;
      probe_q <= '0;
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (i_abort)
      begin
        busy_q <= 1'b0;
      end
      else if (i_start && !busy_q)
      begin
        busy_q <= 1'b1;
        probe_q <= {1'b1, {(RES_BITS-1){1'b0}}};
        approximation_shift_reg_q <= {1'b1, {(RES_BITS-1){1'b0}}};
        cnt_q <= i_step_cyc;
      end
      else if (busy_q)
      begin
        if (cnt_q > 8'h01)
        begin
          cnt_q <= cnt_q - 8'h01;
        end
        else
        begin
          approximation_shift_reg_q <= (i_cmp_ge ? approximation_shift_reg_q
                                        : (approximation_shift_reg_q & ~probe_q)) | (probe_q >> 1);
          probe_q <= probe_q >> 1;
          cnt_q <= i_step_cyc;
          if (probe_q[0])
          begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end
    end
  end
endmodule : adc_sar_core
`default_nettype wire

/* File: design/adc10_sequencer_control.sv */
`timescale 1ns/1ps
`default_nettype none
module adc10_sequencer_control
  import adc_ctl_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // cpu memory access
  input wire cpu_req_t i_cpu,
  output logic [15:0] o_rdata,
  // analog front end
  input wire logic i_cmp_ge,
  input wire logic i_ext_trigger_in,
  output logic [2:0] o_chan,
  output logic [RES_BITS-1:0] o_tap,
  // events
  output logic o_conversion_done_irq,
  output logic o_busy
);
  mode_t converter_mode_reg_q;
  logic [2:0] channel_select_reg_q;
  logic [7:0] rising_edge_en_reg_q;
  logic [7:0] falling_edge_en_reg_q;
  logic [15:0] conversion_result_reg_q;
  logic trig_prev_q;
  logic restart_q;
  logic irq_q;
  logic [15:0] rdata_q;
  logic [2:0] chan_q;
  logic [RES_BITS-1:0] tap_q;
  logic busy_q;
  logic mode_wr;
  logic chan_wr;
  logic [7:0] mode_new;
  logic [7:0] step_cyc;
  logic rise;
  logic fall;
  logic edge_ok;
  logic start;
  logic abort;
  logic sar_busy;
  logic sar_done;
  logic [RES_BITS-1:0] sar_trial;
  logic [RES_BITS-1:0] sar_value;

  // write decode
  assign mode_wr = i_cpu.wr && i_cpu.addr == MODE_ADDR;
  assign chan_wr = i_cpu.wr && i_cpu.addr == CHAN_ADDR;

  always_comb
  begin
    mode_new = converter_mode_reg_q;
    if (i_cpu.bit_wr)
    begin
      mode_new[i_cpu.bit_idx] = i_cpu.bit_val;
    end
    else
    begin
      mode_new = i_cpu.wdata;
    end
    mode_new = mode_new & MODE_WMASK;
  end

  // mode register
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      converter_mode_reg_q <= MODE_RESET;
    end
    else if (mode_wr)
    begin
      converter_mode_reg_q <= mode_new;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      channel_select_reg_q <= CHAN_RESET;
    end
    else if (chan_wr)
    begin
      channel_select_reg_q <= i_cpu.bit_wr ? channel_select_reg_q : i_cpu.wdata[2:0];
    end
  end

  // edge enable registers, bit or byte writes
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rising_edge_en_reg_q <= 8'h00;
      falling_edge_en_reg_q <= 8'h00;
    end
    else if (i_cpu.wr)
    begin
      if (i_cpu.addr == RISE_EN_ADDR)
      begin
        if (i_cpu.bit_wr)
          rising_edge_en_reg_q[i_cpu.bit_idx] <= i_cpu.bit_val;
        else
          rising_edge_en_reg_q <= i_cpu.wdata;
      end
      if (i_cpu.addr == FALL_EN_ADDR)
      begin
        if (i_cpu.bit_wr)
          falling_edge_en_reg_q[i_cpu.bit_idx] <= i_cpu.bit_val;
        else
          falling_edge_en_reg_q <= i_cpu.wdata;
      end
    end
  end

  // trigger edge detection
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      trig_prev_q <= 1'b0;
    else
      trig_prev_q <= i_ext_trigger_in;
  end

  assign rise = i_ext_trigger_in && !trig_prev_q;
  assign fall = !i_ext_trigger_in && trig_prev_q;

  always_comb
  begin
    unique case (converter_mode_reg_q.edge_sel)
      EDGE_NONE: edge_ok = 1'b0;
      EDGE_FALL: edge_ok = fall && falling_edge_en_reg_q[TRIG_EN_BIT];
      EDGE_RISE: edge_ok = rise && rising_edge_en_reg_q[TRIG_EN_BIT];
      EDGE_BOTH: edge_ok = (fall && falling_edge_en_reg_q[TRIG_EN_BIT])
                           || (rise && rising_edge_en_reg_q[TRIG_EN_BIT]);
    endcase
  end

  // conversion time select
  always_comb
  begin
    unique case (converter_mode_reg_q.time_sel)
      3'h0: step_cyc = 8'(STEP_CYC_0);
      3'h1: step_cyc = 8'(STEP_CYC_1);
      default: step_cyc = 8'(STEP_CYC_OTHER);
    endcase
  end

  assign abort = mode_wr || chan_wr || !converter_mode_reg_q.run;

  assign start = !abort && converter_mode_reg_q.run && !sar_busy
                 && (converter_mode_reg_q.src_trig ? edge_ok : restart_q);

  // software mode: rearm after abort or done
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      restart_q <= 1'b0;
    else
      restart_q <= !converter_mode_reg_q.src_trig;
  end

  adc_sar_core u_sar (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_start(start),
    .i_abort(abort),
    .i_step_cyc(step_cyc),
    .i_cmp_ge(i_cmp_ge),
    .o_trial(sar_trial),
    .o_busy(sar_busy),
    .o_done(sar_done),
    .o_value(sar_value)
  );

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      conversion_result_reg_q <= RESULT_RESET;
    else if (sar_done && !abort)
      conversion_result_reg_q <= {sar_value, {RES_SHIFT{1'b0}}};
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      irq_q <= 1'b0;
    else
      irq_q <= sar_done && !abort;
  end

  // read mux, result low six bits zero
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rdata_q <= 16'h0000;
    else if (i_cpu.rd)
    begin
      unique case (i_cpu.addr)
        MODE_ADDR: rdata_q <= {8'h00, converter_mode_reg_q};
        CHAN_ADDR: rdata_q <= {13'h0000, channel_select_reg_q};
        RISE_EN_ADDR: rdata_q <= {8'h00, rising_edge_en_reg_q};
        FALL_EN_ADDR: rdata_q <= {8'h00, falling_edge_en_reg_q};
        RESULT_ADDR: rdata_q <= conversion_result_reg_q & 16'hFFC0;
        default: rdata_q <= 16'h0000;
      endcase
    end
  end

  // analog side drive
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      chan_q <= 3'h0;
      tap_q <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      chan_q <= channel_select_reg_q;
      tap_q <= sar_trial;
      busy_q <= sar_busy;
    end
  end

  assign o_rdata = rdata_q;
  assign o_chan = chan_q;
  assign o_tap = tap_q;
  assign o_conversion_done_irq = irq_q;
  assign o_busy = busy_q;

  // checks
  // result low bits zero
  result_low_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    conversion_result_reg_q[5:0] == 6'h00) else $error("result low bits nonzero");
  // done loads result
  result_load_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (sar_done && !abort) |=> conversion_result_reg_q == {$past(sar_value), 6'h00})
    else $error("result not loaded");
  // irq follows done
  irq_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (sar_done && !abort) |=> o_conversion_done_irq) else $error("missing irq");
  // stopped means idle
  run_stop_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !converter_mode_reg_q.run |=> !sar_busy) else $error("busy while stopped");
  // bit zero fixed
  mode_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    converter_mode_reg_q.zero == 1'b0) else $error("mode bit0 set");
  // channel write aborts
  chan_abort_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (chan_wr && sar_busy) |=> !sar_busy) else $error("no abort on channel write");
  // trigger mode needs edge
  trig_wait_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (converter_mode_reg_q.src_trig && !sar_busy && !edge_ok) |=> !sar_busy)
    else $error("start without edge");
  // software mode restarts
  sw_restart_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (sar_done && converter_mode_reg_q.run && !converter_mode_reg_q.src_trig && !abort
     && !i_cpu.wr) |=> ##1 sar_busy) else $error("no restart");
endmodule : adc10_sequencer_control
`default_nettype wire

/* File: tb/adc_front_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
  // front end view
  input wire logic [2:0] i_chan,
  input wire logic [9:0] i_tap,
  // comparator answer
  output logic o_cmp_ge
);
  // channel c holds level {c, 35h}, so its ideal code is known exactly
  assign o_cmp_ge = ({i_chan, 7'h35} >= i_tap);
endmodule : adc_front_model
`default_nettype wire

/* File: tb/adc10_sequencer_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc10_sequencer_control_tb
  import adc_ctl_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b;
  cpu_req_t cpu;
  logic [15:0] rdata;
  logic cmp;
  logic trg;
  logic [2:0] chan;
  logic [9:0] tap;
  logic irq;
  logic busy;
  logic [15:0] d;
  logic g;
  int err_total;
  int check_count;
  int irq_n;

  // 125 MHz clock
  always #4 clk = ~clk;

  adc10_sequencer_control u_dut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_cpu(cpu), .o_rdata(rdata), .i_cmp_ge(cmp),
    .i_ext_trigger_in(trg), .o_chan(chan), .o_tap(tap), .o_conversion_done_irq(irq), .o_busy(busy)
  );

  adc_front_model u_front (.i_chan(chan), .i_tap(tap), .o_cmp_ge(cmp));

  // count done pulses
  always @(posedge clk)
    if (irq === 1'b1)
      irq_n <= irq_n + 1;

  task conclude;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one bus request, released at the edge that takes it
  task req(input cpu_req_t r);
    @(posedge clk);
    cpu <= r;
    @(posedge clk);
    cpu <= '0;
  endtask : req

  task wr(input logic [15:0] a, input logic [7:0] v);
    req('{1'b1, 1'b0, 3'h0, 1'b0, 1'b0, a, v});
  endtask : wr

  task bw(input logic [15:0] a, input logic [2:0] i, input logic v);
    req('{1'b1, 1'b1, i, v, 1'b0, a, 8'h00});
  endtask : bw

  task rd(input logic [15:0] a, output logic [15:0] v);
    req('{1'b0, 1'b0, 3'h0, 1'b0, 1'b1, a, 8'h00});
    @(posedge clk);
    #1;
    v = rdata;
  endtask : rd

  // bounded wait for a new done pulse
  task wait_irq(input int n, output logic got);
    int s;
    s = irq_n;
    for (int i = 0; i < n && irq_n == s; i++)
      @(posedge clk);
    #1;
    got = (irq_n != s);
  endtask : wait_irq

  // drive trigger at an edge, then watch for a done pulse
  task trig(input logic v, input logic exp);
    @(posedge clk);
    trg <= v;
    wait_irq(400, g);
    chk(g, exp);
  endtask : trig

  // watchdog
  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    conclude;
  end

  // main sequence
  initial
  begin
    rst_b = 1'b0;
    cpu = '0;
    trg = 1'b0;
    err_total = 0;
    check_count = 0;
    irq_n = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(MODE_ADDR, d);
    chk(d, {8'h00, MODE_RESET});
    rd(CHAN_ADDR, d);
    chk(d, 16'h0000);
    rd(RESULT_ADDR, d);
    chk(d, RESULT_RESET);
    wr(MODE_ADDR, 8'h3F);
    rd(MODE_ADDR, d);
    chk(d, 16'h003E);
    // software start on channel 5, runs back to back
    wr(CHAN_ADDR, 8'h05);
    wr(MODE_ADDR, 8'h80);
    wait_irq(400, g);
    chk(g, 1'b1);
    chk({13'h0, chan}, 16'h0005);
    rd(RESULT_ADDR, d);
    chk(d, {3'h5, 7'h35, 6'h00});
    chk({15'h0, busy}, 16'h0001);
    wait_irq(400, g);
    chk(g, 1'b1);
    // result taken before the channel change
    rd(RESULT_ADDR, d);
    chk(d, {3'h5, 7'h35, 6'h00});
    wr(CHAN_ADDR, 8'h02);
    wait_irq(400, g);
    chk(g, 1'b1);
    rd(RESULT_ADDR, d);
    chk(d, {3'h2, 7'h35, 6'h00});
    // single bit write clears run
    bw(MODE_ADDR, 3'h7, 1'b0);
    wait_irq(400, g);
    chk(g, 1'b0);
    chk({15'h0, busy}, 16'h0000);
    rd(MODE_ADDR, d);
    chk(d, 16'h0000);
    // trigger start, edge codes 01 to 11
    wr(RISE_EN_ADDR, 8'h08);
    wr(FALL_EN_ADDR, 8'h08);
    for (int e = 1; e < 4; e++)
    begin
      wr(MODE_ADDR, 8'hC0 | 8'(e << 1));
      wait_irq(200, g);
      chk(g, 1'b0);
      trig(1'b1, e[1]);
      trig(1'b0, e[0]);
      wait_irq(300, g);
      chk(g, 1'b0);
      chk({15'h0, busy}, 16'h0000);
    end
    // rising edge enable off gates the rising edge
    wr(RISE_EN_ADDR, 8'h00);
    wr(MODE_ADDR, 8'hC6);
    trig(1'b1, 1'b0);
    trig(1'b0, 1'b1);
    // reset in mid-run clears a loaded result and the channel and mode registers
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(RESULT_ADDR, d);
    chk(d, RESULT_RESET);
    rd(CHAN_ADDR, d);
    chk(d, 16'h0000);
    rd(MODE_ADDR, d);
    chk(d, {8'h00, MODE_RESET});
    conclude;
  end
endmodule : adc10_sequencer_control_tb
`default_nettype wire
